// ---- hdl/lcig_defs.vh ----
// Register map, field positions and reset values of the logic cell input block
`ifndef LCIG_DEFS_VH
`define LCIG_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LCIG_ADDR_W           4
`define LCIG_OFF_CONTROL      4'h0
`define LCIG_OFF_POLARITY     4'h1
`define LCIG_OFF_DSEL0        4'h2
`define LCIG_OFF_DSEL1        4'h3
`define LCIG_OFF_DSEL2        4'h4
`define LCIG_OFF_DSEL3        4'h5
`define LCIG_OFF_GSEL0        4'h6
`define LCIG_OFF_GSEL1        4'h7
`define LCIG_OFF_GSEL2        4'h8
`define LCIG_OFF_GSEL3        4'h9
`define LCIG_OFF_IRQ_STATUS   4'hA
`define LCIG_OFF_IRQ_MASK     4'hB

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define LCIG_CTL_ENABLE       7
`define LCIG_CTL_RESULT       5
`define LCIG_CTL_RISE_EN      4
`define LCIG_CTL_FALL_EN      3
`define LCIG_CTL_MODE_HI      2
`define LCIG_CTL_MODE_LO      0
`define LCIG_CTL_RESET        8'h00

// ----------------------------------------------------------------------
// Polarity register fields
// ----------------------------------------------------------------------
`define LCIG_POL_OUT          7
`define LCIG_POL_GATE_HI      3
`define LCIG_POL_GATE_LO      0
`define LCIG_POL_OUT_RESET    1'b0

// ----------------------------------------------------------------------
// Source select and interrupt fields
// ----------------------------------------------------------------------
`define LCIG_SEL_W            6
`define LCIG_SRC_COUNT        64
`define LCIG_IRQ_EDGE         0
`define LCIG_IRQ_RESET        1'b0

// ----------------------------------------------------------------------
// Cell function modes
// ----------------------------------------------------------------------
`define LCIG_MODE_AND_OR      3'h0
`define LCIG_MODE_OR_XOR      3'h1
`define LCIG_MODE_AND4        3'h2
`define LCIG_MODE_SR_LATCH    3'h3
`define LCIG_MODE_DFF_SR      3'h4
`define LCIG_MODE_DFF2_R      3'h5
`define LCIG_MODE_JK_R        3'h6
`define LCIG_MODE_LATCH_SR    3'h7

`endif

// ---- hdl/lcig_cell_func.v ----
// Logic function core: combines the four polarity-adjusted gate outputs
`timescale 1ns/1ps
`include "lcig_defs.vh"

module lcig_cell_func
(
   // Clock and reset
   input  wire       clk,
   input  wire       reset_n,
   // Configuration
   input  wire [2:0] cellFunctionSelect,
   // Gate outputs after polarity
   input  wire [3:0] gateIn,
   // Function result
   output reg        funcOut
);

   reg  stateReg;
   reg  stateNext;
   reg  clkGateReg;
   wire clkRise;

   // ----------------------------------------------------------------------
   // Storage modes
   // ----------------------------------------------------------------------
   // Gate 0 acts as the storage clock; its edge is found against the value sampled
   // last cycle, so flip-flop modes respond in the same cycle the gate rises.
   assign clkRise = gateIn[0] & ~clkGateReg;

   always @*
   begin
      stateNext = stateReg;
      case (cellFunctionSelect)
         `LCIG_MODE_SR_LATCH:
         begin
            if (gateIn[0] | gateIn[1])
               stateNext = 1'b1;
            else if (gateIn[2] | gateIn[3])
               stateNext = 1'b0;
         end
         `LCIG_MODE_DFF_SR:
         begin
            if (gateIn[2])
               stateNext = 1'b0;
            else if (gateIn[3])
               stateNext = 1'b1;
            else if (clkRise)
               stateNext = gateIn[1];
         end
         `LCIG_MODE_DFF2_R:
         begin
            if (gateIn[2])
               stateNext = 1'b0;
            else if (clkRise)
               stateNext = gateIn[1] & gateIn[3];
         end
         `LCIG_MODE_JK_R:
         begin
            if (gateIn[2])
               stateNext = 1'b0;
            else if (clkRise)
               stateNext = (gateIn[1] & ~stateReg) | (~gateIn[3] & stateReg);
         end
         `LCIG_MODE_LATCH_SR:
         begin
            if (gateIn[2])
               stateNext = 1'b0;
            else if (gateIn[3])
               stateNext = 1'b1;
            else if (gateIn[0])
               stateNext = gateIn[1];
         end
         default:
            stateNext = stateReg;
      endcase
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         stateReg   <= 1'b0;
         clkGateReg <= 1'b0;
      end
      else
      begin
         stateReg   <= stateNext;
         clkGateReg <= gateIn[0];
      end
   end

   // ----------------------------------------------------------------------
   // Result select
   // ----------------------------------------------------------------------
   always @*
   begin
      case (cellFunctionSelect)
         `LCIG_MODE_AND_OR:
            funcOut = (gateIn[0] & gateIn[1]) | (gateIn[2] & gateIn[3]);
         `LCIG_MODE_OR_XOR:
            funcOut = (gateIn[0] | gateIn[1]) ^ (gateIn[2] | gateIn[3]);
         `LCIG_MODE_AND4:
            funcOut = &gateIn;
         default:
            funcOut = stateNext;
      endcase
   end

endmodule // lcig_cell_func

// ---- hdl/lcig_logic_cell.v ----
// Configurable logic cell: source selection, gating, polarity and registers
//
// How it works
// RULE_01: The final cell output is inverted when the output invert bit is set.
// RULE_02: Each gate output is inverted before the cell function when its polarity bit is set.
// RULE_03: Source select registers hold six bits and read the upper two as zero.
// RULE_04: The first source select field picks the signal for data line 1.
// RULE_05: The second source select field picks the signal for data line 2.
// RULE_06: The third source select field picks the signal for data line 3.
// RULE_07: The fourth source select field picks the signal for data line 4.
// RULE_08: Gate select bits 7, 5, 3 and 1 admit the true form of lines 4, 3, 2 and 1.
// RULE_09: Gate select bits 6, 4, 2 and 0 admit the inverted form of lines 4, 3, 2 and 1.
// RULE_10: Reset clears the output invert bit and leaves all select and gate settings alone.
// RULE_11: A gate is the OR of its admitted line forms and is zero when none is admitted.
// RULE_12: The three-bit function field picks one of eight logic or storage functions.
// RULE_13: With the enable bit clear the cell output is held at zero.
// RULE_14: Enabled rising or falling edges of the cell output set the edge flag.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "lcig_defs.vh"

module lcig_logic_cell
(
   // Clock and reset
   input  wire                    clk,
   input  wire                    reset_n,
   // Register port
   input  wire [`LCIG_ADDR_W-1:0] regAddr,
   input  wire [7:0]              regWdata,
   input  wire                    regWrite,
   input  wire                    regRead,
   output reg  [7:0]              regRdata,
   // Selectable sources
   input  wire [`LCIG_SRC_COUNT-1:0] sourceBus,
   // Cell output and interrupt
   output reg                     cellResult,
   output reg                     irqOut
);

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   // One source out of the sixty-four by a six-bit index
   function pickSource;
      input [`LCIG_SRC_COUNT-1:0] bus;
      input [`LCIG_SEL_W-1:0]     sel;
      begin
         pickSource = bus[sel];
      end
   endfunction

   // Write strobe decode for one register index; every register write goes
   // through it so no two registers can decode the same index differently
   function writeHit;
      input                    strobe;
      input [`LCIG_ADDR_W-1:0] addr;
      input [`LCIG_ADDR_W-1:0] index;
      begin
         writeHit = strobe && (addr == index);
      end
   endfunction

   // Source select readback: only six bits exist, the upper two read zero
   function [7:0] selReadback;
      input [`LCIG_SEL_W-1:0] sel;
      begin
         selReadback = {2'b00, sel}; // [RULE_03]
      end
   endfunction

   // OR of admitted true and inverted forms; odd bits true, even inverted
   function gateOr;
      input [7:0] admit;
      input [3:0] lines;
      integer     i;
      begin
         gateOr = 1'b0;
         for (i = 0; i < 4; i = i + 1)
         begin
            gateOr = gateOr | (admit[2*i+1] & lines[i]); // [RULE_08]
            gateOr = gateOr | (admit[2*i] & ~lines[i]);  // [RULE_09]
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   reg        cellEnable_reg;
   reg        risingEdgeFlagEnable_reg;
   reg        fallingEdgeFlagEnable_reg;
   reg  [2:0] cellFunctionSelect_reg;
   reg        cellOutputInvert_reg;
   reg  [3:0] gateOutputInvert_reg;
   reg  [`LCIG_SEL_W-1:0] dataLineSource_reg [0:3];
   reg  [7:0] gateAdmit_reg [0:3];
   reg        cellEdgeFlag_reg;
   reg        irqMask_reg;

   reg        cellEdgeFlag_next;
   reg  [7:0] readData_next;
   reg        cellResult_next;

   wire [3:0] dataLine;
   wire [3:0] gateRaw;
   wire [3:0] gateAdjusted;
   wire       funcOut;
   wire       edgeRise;
   wire       edgeFall;
   wire       flagClear;

   // ----------------------------------------------------------------------
   // Control and interrupt registers (reset to defined values)
   // ----------------------------------------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cellEnable_reg            <= 1'b0;
         risingEdgeFlagEnable_reg  <= 1'b0;
         fallingEdgeFlagEnable_reg <= 1'b0;
         cellFunctionSelect_reg    <= 3'h0;
         cellOutputInvert_reg      <= `LCIG_POL_OUT_RESET; // [RULE_10]
         cellEdgeFlag_reg          <= `LCIG_IRQ_RESET;
         irqMask_reg               <= 1'b0;
      end
      else
      begin
         cellEdgeFlag_reg <= cellEdgeFlag_next;
         if (writeHit(regWrite, regAddr, `LCIG_OFF_CONTROL))
         begin
            cellEnable_reg            <= regWdata[`LCIG_CTL_ENABLE];
            risingEdgeFlagEnable_reg  <= regWdata[`LCIG_CTL_RISE_EN];
            fallingEdgeFlagEnable_reg <= regWdata[`LCIG_CTL_FALL_EN];
            cellFunctionSelect_reg    <=
               regWdata[`LCIG_CTL_MODE_HI:`LCIG_CTL_MODE_LO];
         end
         if (writeHit(regWrite, regAddr, `LCIG_OFF_POLARITY))
            cellOutputInvert_reg <= regWdata[`LCIG_POL_OUT];
         if (writeHit(regWrite, regAddr, `LCIG_OFF_IRQ_MASK))
            irqMask_reg <= regWdata[`LCIG_IRQ_EDGE];
      end
   end

   // ----------------------------------------------------------------------
   // Selection and gating registers
   // ----------------------------------------------------------------------
   // No reset on purpose: these settings power up unknown and must survive
   // every reset, so software reloads them only after power-up.
   always @(posedge clk)
   begin
      if (writeHit(regWrite, regAddr, `LCIG_OFF_POLARITY))
         gateOutputInvert_reg <= regWdata[`LCIG_POL_GATE_HI:`LCIG_POL_GATE_LO]; // [RULE_10]
      if (writeHit(regWrite, regAddr, `LCIG_OFF_DSEL0))
         dataLineSource_reg[0] <= regWdata[`LCIG_SEL_W-1:0]; // [RULE_03]
      if (writeHit(regWrite, regAddr, `LCIG_OFF_DSEL1))
         dataLineSource_reg[1] <= regWdata[`LCIG_SEL_W-1:0]; // [RULE_03]
      if (writeHit(regWrite, regAddr, `LCIG_OFF_DSEL2))
         dataLineSource_reg[2] <= regWdata[`LCIG_SEL_W-1:0]; // [RULE_03]
      if (writeHit(regWrite, regAddr, `LCIG_OFF_DSEL3))
         dataLineSource_reg[3] <= regWdata[`LCIG_SEL_W-1:0]; // [RULE_03]
      if (writeHit(regWrite, regAddr, `LCIG_OFF_GSEL0))
         gateAdmit_reg[0] <= regWdata;
      if (writeHit(regWrite, regAddr, `LCIG_OFF_GSEL1))
         gateAdmit_reg[1] <= regWdata;
      if (writeHit(regWrite, regAddr, `LCIG_OFF_GSEL2))
         gateAdmit_reg[2] <= regWdata;
      if (writeHit(regWrite, regAddr, `LCIG_OFF_GSEL3))
         gateAdmit_reg[3] <= regWdata;
   end

   // ----------------------------------------------------------------------
   // Data lines
   // ----------------------------------------------------------------------
   assign dataLine[0] = pickSource(sourceBus, dataLineSource_reg[0]); // [RULE_04]
   assign dataLine[1] = pickSource(sourceBus, dataLineSource_reg[1]); // [RULE_05]
   assign dataLine[2] = pickSource(sourceBus, dataLineSource_reg[2]); // [RULE_06]
   assign dataLine[3] = pickSource(sourceBus, dataLineSource_reg[3]); // [RULE_07]

   // ----------------------------------------------------------------------
   // Gates and gate polarity
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : gateSlice
         assign gateRaw[g]      = gateOr(gateAdmit_reg[g], dataLine); // [RULE_11]
         assign gateAdjusted[g] = gateRaw[g] ^ gateOutputInvert_reg[g]; // [RULE_02]
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Cell function
   // ----------------------------------------------------------------------
   lcig_cell_func u_cellFunc
   (
      .clk                (clk),
      .reset_n            (reset_n),
      .cellFunctionSelect (cellFunctionSelect_reg), // [RULE_12]
      .gateIn             (gateAdjusted),
      .funcOut            (funcOut)
   );

   // Output polarity first, then the enable forces zero, so a disabled
   // cell stays low even with the output invert bit set.
   always @*
   begin
      cellResult_next = 1'b0;
      if (cellEnable_reg) // [RULE_13]
         cellResult_next = funcOut ^ cellOutputInvert_reg; // [RULE_01]
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         cellResult <= 1'b0;
      else
         cellResult <= cellResult_next;
   end

   // ----------------------------------------------------------------------
   // Edge flag and interrupt
   // ----------------------------------------------------------------------
   // Edges come from the next result, so the flag sets on the edge the output moves
   assign edgeRise  = cellResult_next & ~cellResult & risingEdgeFlagEnable_reg;
   assign edgeFall  = ~cellResult_next & cellResult & fallingEdgeFlagEnable_reg;
   assign flagClear = writeHit(regWrite, regAddr, `LCIG_OFF_IRQ_STATUS) &&
                      regWdata[`LCIG_IRQ_EDGE];

   // A new edge in the clearing cycle wins, so no event is lost
   always @*
   begin
      cellEdgeFlag_next = cellEdgeFlag_reg & ~flagClear;
      if (edgeRise | edgeFall) // [RULE_14]
         cellEdgeFlag_next = 1'b1;
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         irqOut <= 1'b0;
      else
         irqOut <= cellEdgeFlag_next & irqMask_reg;
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always @*
   begin
      readData_next = 8'h00;
      case (regAddr)
         `LCIG_OFF_CONTROL:
         begin
            readData_next[`LCIG_CTL_ENABLE]  = cellEnable_reg;
            readData_next[`LCIG_CTL_RESULT]  = cellResult;
            readData_next[`LCIG_CTL_RISE_EN] = risingEdgeFlagEnable_reg;
            readData_next[`LCIG_CTL_FALL_EN] = fallingEdgeFlagEnable_reg;
            readData_next[`LCIG_CTL_MODE_HI:`LCIG_CTL_MODE_LO] =
               cellFunctionSelect_reg;
         end
         `LCIG_OFF_POLARITY:
         begin
            readData_next[`LCIG_POL_OUT] = cellOutputInvert_reg;
            readData_next[`LCIG_POL_GATE_HI:`LCIG_POL_GATE_LO] =
               gateOutputInvert_reg;
         end
         `LCIG_OFF_DSEL0:
            readData_next = selReadback(dataLineSource_reg[0]); // [RULE_03]
         `LCIG_OFF_DSEL1:
            readData_next = selReadback(dataLineSource_reg[1]); // [RULE_03]
         `LCIG_OFF_DSEL2:
            readData_next = selReadback(dataLineSource_reg[2]); // [RULE_03]
         `LCIG_OFF_DSEL3:
            readData_next = selReadback(dataLineSource_reg[3]); // [RULE_03]
         `LCIG_OFF_GSEL0:
            readData_next = gateAdmit_reg[0];
         `LCIG_OFF_GSEL1:
            readData_next = gateAdmit_reg[1];
         `LCIG_OFF_GSEL2:
            readData_next = gateAdmit_reg[2];
         `LCIG_OFF_GSEL3:
            readData_next = gateAdmit_reg[3];
         `LCIG_OFF_IRQ_STATUS:
            readData_next[`LCIG_IRQ_EDGE] = cellEdgeFlag_reg;
         `LCIG_OFF_IRQ_MASK:
            readData_next[`LCIG_IRQ_EDGE] = irqMask_reg;
         default:
            readData_next = 8'h00;
      endcase
   end

   // Read data is held until the next read so the bus never sees a glitch
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         regRdata <= 8'h00;
      else if (regRead)
         regRdata <= readData_next;
   end

endmodule // lcig_logic_cell

// ---- dv/lcig_logic_cell_chk.sv ----
// Assertion checker for the logic cell register port, output and interrupt
`timescale 1ns/1ps
`include "lcig_defs.vh"
module lcig_logic_cell_chk
(
   // Clock and reset
   input wire                       clk,
   input wire                       reset_n,
   // Register port
   input wire [`LCIG_ADDR_W-1:0]    regAddr,
   input wire [7:0]                 regWdata,
   input wire                       regWrite,
   input wire                       regRead,
   input wire [7:0]                 regRdata,
   // Sources and outputs
   input wire [`LCIG_SRC_COUNT-1:0] sourceBus,
   input wire                       cellResult,
   input wire                       irqOut
);
   reg [7:0] ctlModel;
   reg       outInvModel;
   reg       maskModel;

   // ----------------------------------------------------------------
   // Shadow of the writable settings the assertions depend on
   // ----------------------------------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctlModel    <= 8'h00;
         outInvModel <= 1'b0;
         maskModel   <= 1'b0;
      end
      else if (regWrite)
      begin
         if (regAddr == `LCIG_OFF_CONTROL)
            ctlModel <= regWdata;
         if (regAddr == `LCIG_OFF_POLARITY)
            outInvModel <= regWdata[7];
         if (regAddr == `LCIG_OFF_IRQ_MASK)
            maskModel <= regWdata[0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   sequence s_flagClear;
      regWrite && regAddr == `LCIG_OFF_IRQ_STATUS && regWdata[0];
   endsequence
   property p_unmapRead;
      regRead && regAddr >= 4'hC |=> regRdata == 8'h00;
   endproperty
   property p_selUpper;
      regRead && regAddr >= `LCIG_OFF_DSEL0 && regAddr <= `LCIG_OFF_DSEL3
         |=> regRdata[7:6] == 2'h0;
   endproperty
   property p_holdRdata;
      !regRead |=> $stable(regRdata);
   endproperty
   property p_polRead;
      regRead && regAddr == `LCIG_OFF_POLARITY
         |=> regRdata[7] == outInvModel && regRdata[6:4] == 3'h0;
   endproperty
   property p_resultRead;
      regRead && regAddr == `LCIG_OFF_CONTROL
         |=> regRdata[5] == $past(cellResult) && !regRdata[6];
   endproperty
   property p_disabledLow;
      (!ctlModel[`LCIG_CTL_ENABLE]) [*2] |-> !cellResult;
   endproperty
   property p_maskedQuiet;
      (!maskModel) [*2] |-> !irqOut;
   endproperty
   property p_irqCause;
      $rose(irqOut) && $past(maskModel) && $past(maskModel, 2)
         |-> ($rose(cellResult) && $past(ctlModel[`LCIG_CTL_RISE_EN]))
          || ($fell(cellResult) && $past(ctlModel[`LCIG_CTL_FALL_EN]));
   endproperty
   property p_clearQuiet;
      s_flagClear ##1 $stable(cellResult) [*2] |-> !irqOut;
   endproperty

   a_unmapRead: assert property (p_unmapRead) else $error("unmapped read not zero");
   a_selUpper: assert property (p_selUpper) else $error("select upper bits set");
   a_holdRdata: assert property (p_holdRdata) else $error("read data moved without read");
   a_polRead: assert property (p_polRead) else $error("output invert bit wrong");
   a_resultRead: assert property (p_resultRead) else $error("result bit mismatch");
   a_disabledLow: assert property (p_disabledLow) else $error("disabled cell not low");
   a_maskedQuiet: assert property (p_maskedQuiet) else $error("masked interrupt raised");
   a_irqCause: assert property (p_irqCause) else $error("interrupt without edge");
   a_clearQuiet: assert property (p_clearQuiet) else $error("flag survived clear");
endmodule // lcig_logic_cell_chk

bind lcig_logic_cell lcig_logic_cell_chk u_chk (.clk(clk), .reset_n(reset_n),
   .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .regRdata(regRdata), .sourceBus(sourceBus), .cellResult(cellResult), .irqOut(irqOut));

// ---- dv/lcig_src_model.sv ----
// Behavioural model of the selectable source signals feeding the cell
`timescale 1ns/1ps
module lcig_src_model
(
   // Clock
   input  wire        clk,
   // Levels requested by the bench
   input  wire [63:0] srcLevel,
   // Sources change only at clock edges, as synchronous peripherals do
   output reg  [63:0] sourceBus
);
   initial sourceBus = 64'h0;
   always @(posedge clk)
   begin
      sourceBus <= srcLevel;
   end
endmodule // lcig_src_model

// ---- dv/lcig_tb.sv ----
// Self-checking bench for the logic cell input gating block
`timescale 1ns/1ps
`include "lcig_defs.vh"
module tb;
   reg         clk = 1'b0;
   reg         reset_n = 1'b0;
   reg  [3:0]  regAddr = 4'h0;
   reg  [7:0]  regWdata = 8'h00;
   reg         regWrite = 1'b0;
   reg         regRead = 1'b0;
   reg  [63:0] srcLevel = 64'h0;
   wire [7:0]  regRdata;
   wire [63:0] sourceBus;
   wire        cellResult;
   wire        irqOut;
   integer     fail_count = 0;
   integer     checked = 0;
   integer     b, v, p, n;
   reg  [7:0]  rd;
   reg  [7:0]  polTab [0:2];
   reg  [5:0]  srcIdx [0:3];
   reg         expBit;
   // Polarity steps and expected results of the OR-XOR, latch and flip-flop sequence
   localparam [71:0] MODE_POL = 72'h01_05_04_01_00_04_02_03_04;
   localparam [8:0]  MODE_EXP = 9'b1_0_0_1_1_0_0_1_0;

   always #25 clk = ~clk;

   lcig_src_model u_src (.clk(clk), .srcLevel(srcLevel), .sourceBus(sourceBus));
   lcig_logic_cell u_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sourceBus(sourceBus),
      .cellResult(cellResult), .irqOut(irqOut));

   // ----------------------------------------------------------------
   // Access and comparison tasks
   // ----------------------------------------------------------------
   task check(input string what, input [7:0] seen, input [7:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp)
         begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task tick(input integer cnt);
      repeat (cnt) @(posedge clk);
   endtask
   // An idle cycle after each access keeps strobes from being driven twice in one step
   task regWr(input [3:0] a, input [7:0] d);
      begin
         regAddr  <= a;
         regWdata <= d;
         regWrite <= 1'b1;
         @(posedge clk);
         regWrite <= 1'b0;
         @(posedge clk);
      end
   endtask
   task regRd(input [3:0] a, output [7:0] d);
      begin
         regAddr <= a;
         regRead <= 1'b1;
         @(posedge clk);
         regRead <= 1'b0;
         #1 d = regRdata;
         @(posedge clk);
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checked, fail_count);
         if (fail_count == 0 && checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask

   initial
   begin
      tick(20000);
      fail_count = fail_count + 1;
      complete_run;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      polTab[0] = 8'h02;
      polTab[1] = 8'h03;
      polTab[2] = 8'h82;
      srcIdx[0] = 6'h00;
      srcIdx[1] = 6'h15;
      srcIdx[2] = 6'h2A;
      srcIdx[3] = 6'h3F;
      tick(20);
      reset_n <= 1'b1;
      tick(1);
      regRd(`LCIG_OFF_POLARITY, rd);
      check("outInvert", {7'h0, rd[7]}, 8'h00);
      regRd(4'hC, rd);
      check("unmapped", rd, 8'h00);
      regWr(`LCIG_OFF_POLARITY, 8'h8F);
      reset_n <= 1'b0;
      tick(2);
      reset_n <= 1'b1;
      tick(1);
      regRd(`LCIG_OFF_POLARITY, rd);
      check("polAfterReset", rd, 8'h0F);
      for (n = 0; n < 4; n = n + 1)
      begin
         regWr(`LCIG_OFF_DSEL0 + n[3:0], 8'hC0 | {2'h0, srcIdx[n]});
         regRd(`LCIG_OFF_DSEL0 + n[3:0], rd);
         check("select", rd, {2'h0, srcIdx[n]});
      end
      // Gate 1 forced high by its polarity, gates 2 and 3 low: AND-OR follows gate 0
      regWr(`LCIG_OFF_GSEL1, 8'h00);
      regWr(`LCIG_OFF_GSEL2, 8'h00);
      regWr(`LCIG_OFF_GSEL3, 8'h00);
      regWr(`LCIG_OFF_CONTROL, 8'h80);
      for (p = 0; p < 3; p = p + 1)
      begin
         regWr(`LCIG_OFF_POLARITY, polTab[p]);
         for (b = 0; b < 9; b = b + 1)
         begin
            regWr(`LCIG_OFF_GSEL0, (b == 8) ? 8'h00 : (8'h01 << b));
            for (v = 0; v < 2; v = v + 1)
            begin
               srcLevel <= ~(64'h1 << srcIdx[b / 2 % 4]) ^ {64{v[0]}};
               tick(3);
               expBit = (b == 8) ? 1'b0 : ((b % 2 == 1) ? v[0] : ~v[0]);
               expBit = expBit ^ polTab[p][0] ^ polTab[p][7];
               check("gate0", {7'h0, cellResult}, {7'h0, expBit});
            end
         end
      end
      // Four-input AND of constant gates, one polarity bit dropped at a time
      regWr(`LCIG_OFF_GSEL0, 8'h00);
      regWr(`LCIG_OFF_CONTROL, 8'h82);
      for (n = 0; n < 5; n = n + 1)
      begin
         regWr(`LCIG_OFF_POLARITY, (n == 4) ? 8'h0F : (8'h0F ^ (8'h01 << n)));
         tick(3);
         check("and4", {7'h0, cellResult}, (n == 4) ? 8'h01 : 8'h00);
      end
      // OR-XOR, S-R latch and D flip-flop on constant gates; state carries between steps
      for (n = 0; n < 9; n = n + 1)
      begin
         regWr(`LCIG_OFF_CONTROL, (n < 2) ? 8'h81 : (n < 5) ? 8'h83 : 8'h84);
         regWr(`LCIG_OFF_POLARITY, MODE_POL[71 - 8 * n -: 8]);
         tick(3);
         check("mode", {7'h0, cellResult}, {7'h0, MODE_EXP[8 - n]});
      end
      // Edge flag, mask, clear and disable
      regWr(`LCIG_OFF_POLARITY, 8'h00);
      regWr(`LCIG_OFF_CONTROL, 8'h98);
      regWr(`LCIG_OFF_IRQ_MASK, 8'h01);
      regWr(`LCIG_OFF_IRQ_STATUS, 8'h01);
      tick(1);
      check("irqIdle", {7'h0, irqOut}, 8'h00);
      regWr(`LCIG_OFF_POLARITY, 8'h80);
      tick(1);
      check("inverted", {7'h0, cellResult}, 8'h01);
      check("irqRise", {7'h0, irqOut}, 8'h01);
      regRd(`LCIG_OFF_CONTROL, rd);
      check("control", rd, 8'hB8);
      regRd(`LCIG_OFF_IRQ_STATUS, rd);
      check("status", rd, 8'h01);
      regWr(`LCIG_OFF_IRQ_STATUS, 8'h01);
      check("irqCleared", {7'h0, irqOut}, 8'h00);
      regWr(`LCIG_OFF_CONTROL, 8'h18);
      tick(1);
      check("disabled", {7'h0, cellResult}, 8'h00);
      check("irqFall", {7'h0, irqOut}, 8'h01);
      regWr(`LCIG_OFF_IRQ_MASK, 8'h00);
      tick(1);
      check("irqMasked", {7'h0, irqOut}, 8'h00);
      regRd(`LCIG_OFF_IRQ_STATUS, rd);
      check("statusKept", rd, 8'h01);
      complete_run;
   end
endmodule // tb
